// ==== overlay_alpha_key_gamma_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none

module overlay_alpha_key_gamma_ctrl
	import overlay_blend_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic pix_in_valid,
	input wire pixel_in_t pix_in,
	output logic pix_out_valid,
	output pixel_out_t pix_out,
	output logic main_gamma_bypass
);

	// --------------------------------------------------------------
	// Bus address phase
	// --------------------------------------------------------------
	logic ap_valid;
	logic ap_write;
	logic [31:0] ap_addr;
	logic next_ap_valid;
	logic next_ap_write;
	logic [31:0] next_ap_addr;
	logic take;

	// Zero wait states; every transfer answers OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign take = hready && hsel && htrans[1];

	// hsize is not checked: only whole-word transfers are expected
	always_comb begin
		next_ap_valid = ap_valid;
		next_ap_write = ap_write;
		next_ap_addr = ap_addr;
		if (hready) begin
			next_ap_valid = take;
			next_ap_write = hwrite;
			next_ap_addr = haddr;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_valid <= 1'b0;
			ap_write <= 1'b0;
			ap_addr <= 32'h0000_0000;
		end else begin
			ap_valid <= next_ap_valid;
			ap_write <= next_ap_write;
			ap_addr <= next_ap_addr;
		end
	end

	// --------------------------------------------------------------
	// Write strobes
	// --------------------------------------------------------------
	logic wr_strobe;
	logic wr_blend;
	logic wr_gamma;
	logic wr_key [3];
	logic [15:0] wr_data;

	// Unmapped offsets raise no strobe, so writes there are dropped
	assign wr_strobe = ap_valid && ap_write;
	assign wr_blend = wr_strobe && (ap_addr == ADDR_BLEND);
	assign wr_gamma = wr_strobe && (ap_addr == ADDR_GAMMA);
	assign wr_key[2] = wr_strobe && (ap_addr == ADDR_KEY_RED);
	assign wr_key[1] = wr_strobe && (ap_addr == ADDR_KEY_GREEN);
	assign wr_key[0] = wr_strobe && (ap_addr == ADDR_KEY_BLUE);
	assign wr_data = hwdata[15:0];

	// --------------------------------------------------------------
	// Control registers
	// --------------------------------------------------------------
	logic [15:0] blend_ctrl;
	logic [15:0] gamma_ctrl;
	logic [15:0] next_blend_ctrl;
	logic [15:0] next_gamma_ctrl;

	// Reserved bits are masked on write so they always read zero
	always_comb begin
		next_blend_ctrl = blend_ctrl;
		next_gamma_ctrl = gamma_ctrl;
		if (wr_blend) begin
			next_blend_ctrl = wr_data & BLEND_MASK;
		end
		if (wr_gamma) begin
			next_gamma_ctrl = wr_data & GAMMA_MASK;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			blend_ctrl <= BLEND_RST;
			gamma_ctrl <= GAMMA_RST;
		end else begin
			blend_ctrl <= next_blend_ctrl;
			gamma_ctrl <= next_gamma_ctrl;
		end
	end

	// --------------------------------------------------------------
	// Key colour registers, one per component
	// --------------------------------------------------------------
	// Index 2 is red, 1 green, 0 blue, as in the pixel carrier
	logic [15:0] key_reg [3];
	logic [15:0] next_key_reg [3];

	for (genvar k = 0; k < 3; k++) begin : g_key
		always_comb begin
			next_key_reg[k] = key_reg[k];
			if (wr_key[k]) begin
				next_key_reg[k] = wr_data & KEY_MASK;
			end
		end

		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				key_reg[k] <= KEY_RST;
			end else begin
				key_reg[k] <= next_key_reg[k];
			end
		end
	end

	// --------------------------------------------------------------
	// Read data
	// --------------------------------------------------------------
	logic take_read;
	logic [15:0] rd_word;
	logic [31:0] next_hrdata;

	assign take_read = take && !hwrite;

	// Read from next values so a write just before is seen
	always_comb begin
		rd_word = 16'h0000;
		case (haddr)
			ADDR_BLEND: rd_word = next_blend_ctrl;
			ADDR_KEY_RED: rd_word = next_key_reg[2];
			ADDR_KEY_GREEN: rd_word = next_key_reg[1];
			ADDR_KEY_BLUE: rd_word = next_key_reg[0];
			ADDR_GAMMA: rd_word = next_gamma_ctrl;
			default: rd_word = 16'h0000;
		endcase
		next_hrdata = hrdata;
		// Idle cycles and unmapped reads leave zero on the bus
		if (hready) begin
			next_hrdata = 32'h0000_0000;
			if (take_read) begin
				next_hrdata = {16'h0000, rd_word};
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else begin
			hrdata <= next_hrdata;
		end
	end

	// --------------------------------------------------------------
	// Control decode
	// --------------------------------------------------------------
	logic [1:0] mode;
	logic blend_en;
	logic transp_en;
	logic swap_en;
	logic shift_en;
	logic [7:0] const_alpha;
	rgb_t key_color;

	assign mode = blend_ctrl[MODE_LSB +: 2];
	assign blend_en = blend_ctrl[BIT_BLEND_EN];
	assign transp_en = blend_ctrl[BIT_TRANSP_EN];
	assign swap_en = blend_ctrl[BIT_SWAP];
	assign shift_en = blend_ctrl[BIT_SHIFT_EN];
	assign const_alpha = blend_ctrl[CONST_LSB +: 8];
	assign key_color = {key_reg[2][7:0], key_reg[1][7:0], key_reg[0][7:0]};
	assign main_gamma_bypass = gamma_ctrl[BIT_MAIN_BYPASS];

	// --------------------------------------------------------------
	// Key match, one compare per component
	// --------------------------------------------------------------
	logic key_eq [3];

	// Exact compare: narrow keys must already carry zero low bits
	for (genvar c = 0; c < 3; c++) begin : g_match
		always_comb begin
			key_eq[c] = pix_in.overlay_pixel_color[c] == key_color[c];
		end
	end

	// --------------------------------------------------------------
	// Stage 1: alpha and key match
	// --------------------------------------------------------------
	logic s1_valid;
	pixel_in_t s1_pix;
	logic [7:0] s1_alpha;
	logic s1_show_overlay;
	logic s1_blend_on;
	logic s1_swap;
	logic next_s1_valid;
	pixel_in_t next_s1_pix;
	logic [7:0] next_s1_alpha;
	logic next_s1_show_overlay;
	logic next_s1_blend_on;
	logic next_s1_swap;
	logic [7:0] map_alpha;
	logic [7:0] map_alpha_adj;
	logic [15:0] alpha_prod;
	logic key_hit;

	// Map alpha is only meaningful when software has the ARGB format on
	always_comb begin
		unique case (pix_in.alpha_width)
			AW_1BIT: map_alpha = {pix_in.map_alpha[0], 7'h00};
			AW_4BIT: map_alpha = {pix_in.map_alpha[3:0], 4'h0};
			AW_8BIT: map_alpha = pix_in.map_alpha;
			default: map_alpha = pix_in.map_alpha;
		endcase
		map_alpha_adj = map_alpha;
		if (shift_en && (map_alpha != 8'h00)) begin
			map_alpha_adj = {1'b1, map_alpha[7:1]};
		end
		alpha_prod = map_alpha_adj * const_alpha;
		unique case (mode)
			MODE_CONST: next_s1_alpha = const_alpha;
			MODE_MAP: next_s1_alpha = map_alpha_adj;
			MODE_BOTH: next_s1_alpha = alpha_prod[15:8];
			MODE_RSVD: next_s1_alpha = const_alpha;
		endcase
		key_hit = transp_en && key_eq[2] && key_eq[1] && key_eq[0];
		next_s1_show_overlay = pix_in.in_overlay && !key_hit;
		next_s1_blend_on = next_s1_show_overlay && blend_en;
		next_s1_swap = swap_en;
		next_s1_valid = pix_in_valid;
		next_s1_pix = pix_in;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_valid <= 1'b0;
			s1_pix <= '0;
			s1_alpha <= 8'h00;
			s1_show_overlay <= 1'b0;
			s1_blend_on <= 1'b0;
			s1_swap <= 1'b0;
		end else begin
			s1_valid <= next_s1_valid;
			s1_pix <= next_s1_pix;
			s1_alpha <= next_s1_alpha;
			s1_show_overlay <= next_s1_show_overlay;
			s1_blend_on <= next_s1_blend_on;
			s1_swap <= next_s1_swap;
		end
	end

	// --------------------------------------------------------------
	// Stage 2: per-component blend
	// --------------------------------------------------------------
	rgb_t blended;
	logic [8:0] inv_alpha;

	// Alpha tops out at 255/256, so a full top layer is never reached; swap with zero alpha shows the overlay whole
	assign inv_alpha = ALPHA_ONE - {1'b0, s1_alpha};

	for (genvar c = 0; c < 3; c++) begin : g_chan
		logic [7:0] top;
		logic [7:0] bot;
		logic [17:0] mix;
		always_comb begin
			top = s1_pix.overlay_pixel_color[c];
			bot = s1_pix.main_pixel_color[c];
			if (s1_swap) begin
				top = s1_pix.main_pixel_color[c];
				bot = s1_pix.overlay_pixel_color[c];
			end
			mix = 18'(top) * 18'(s1_alpha) + 18'(bot) * 18'(inv_alpha);
			if (!s1_show_overlay) begin
				blended[c] = s1_pix.main_pixel_color[c];
			end else if (!s1_blend_on) begin
				blended[c] = s1_pix.overlay_pixel_color[c];
			end else begin
				blended[c] = mix[15:8];
			end
		end
	end

	logic next_out_valid;
	pixel_out_t next_out;

	always_comb begin
		next_out_valid = s1_valid;
		next_out.color = blended;
		next_out.from_main = !s1_show_overlay;
		next_out.gamma_lut_use = !s1_show_overlay && !main_gamma_bypass;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pix_out_valid <= 1'b0;
			pix_out <= '0;
		end else begin
			pix_out_valid <= next_out_valid;
			pix_out <= next_out;
		end
	end

endmodule // overlay_alpha_key_gamma_ctrl

`default_nettype wire

// ==== overlay_blend_pkg.sv ====
package overlay_blend_pkg;

	// --------------------------------------------------------------
	// Register indices and byte addresses
	// --------------------------------------------------------------
	localparam logic [11:0] IDX_BLEND = 12'h0836;
	localparam logic [11:0] IDX_KEY_RED = 12'h0838;
	localparam logic [11:0] IDX_KEY_GREEN = 12'h083A;
	localparam logic [11:0] IDX_KEY_BLUE = 12'h083C;
	localparam logic [11:0] IDX_GAMMA = 12'h083E;
	localparam logic [31:0] ADDR_BLEND = {18'h0, IDX_BLEND, 2'h0};
	localparam logic [31:0] ADDR_KEY_RED = {18'h0, IDX_KEY_RED, 2'h0};
	localparam logic [31:0] ADDR_KEY_GREEN = {18'h0, IDX_KEY_GREEN, 2'h0};
	localparam logic [31:0] ADDR_KEY_BLUE = {18'h0, IDX_KEY_BLUE, 2'h0};
	localparam logic [31:0] ADDR_GAMMA = {18'h0, IDX_GAMMA, 2'h0};

	// --------------------------------------------------------------
	// Implemented bits and reset values
	// --------------------------------------------------------------
	localparam logic [15:0] BLEND_MASK = 16'h77FF;
	localparam logic [15:0] KEY_MASK = 16'h00FF;
	localparam logic [15:0] GAMMA_MASK = 16'h7F3F;
	localparam logic [15:0] BLEND_RST = 16'h0000;
	localparam logic [15:0] KEY_RST = 16'h0000;
	localparam logic [15:0] GAMMA_RST = 16'h0000;

	// --------------------------------------------------------------
	// Field positions
	// --------------------------------------------------------------
	localparam int BIT_SHIFT_EN = 14;
	localparam int BIT_SWAP = 13;
	localparam int BIT_TRANSP_EN = 12;
	localparam int MODE_LSB = 9;
	localparam int BIT_BLEND_EN = 8;
	localparam int CONST_LSB = 0;
	localparam int BIT_MAIN_BYPASS = 14;

	// --------------------------------------------------------------
	// Encodings
	// --------------------------------------------------------------
	localparam logic [1:0] MODE_CONST = 2'h0;
	localparam logic [1:0] MODE_MAP = 2'h1;
	localparam logic [1:0] MODE_BOTH = 2'h2;
	localparam logic [1:0] MODE_RSVD = 2'h3;
	localparam logic [1:0] AW_1BIT = 2'h0;
	localparam logic [1:0] AW_4BIT = 2'h1;
	localparam logic [1:0] AW_8BIT = 2'h2;
	localparam logic [8:0] ALPHA_ONE = 9'h100;

	// --------------------------------------------------------------
	// Carriers
	// --------------------------------------------------------------
	typedef logic [2:0][7:0] rgb_t;

	typedef struct packed {
		rgb_t main_pixel_color;
		rgb_t overlay_pixel_color;
		logic [7:0] map_alpha;
		logic [1:0] alpha_width;
		logic in_overlay;
	} pixel_in_t;

	typedef struct packed {
		rgb_t color;
		logic from_main;
		logic gamma_lut_use;
	} pixel_out_t;

endpackage

// ==== overlay_alpha_key_gamma_ctrl_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
module blend_check
	import overlay_blend_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic pix_in_valid,
	input wire pixel_in_t pix_in,
	input wire logic pix_out_valid,
	input wire pixel_out_t pix_out,
	input wire logic main_gamma_bypass
);
	// ----------------------------------------
	// Register shadow, so pixel checks know the mode
	// ----------------------------------------
	logic wr_p;
	logic [31:0] wa;
	logic [15:0] bc;
	rgb_t ky;
	logic hit;
	logic z;
	assign hit = bc[BIT_TRANSP_EN] && pix_in.in_overlay && pix_in.overlay_pixel_color == ky;
	assign z = pix_in_valid && pix_in.in_overlay && !hit && bc[BIT_BLEND_EN] && bc[10] == bc[9]
		&& bc[7:0] == 8'h00;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_p <= 1'b0;
			wa <= 32'h0000_0000;
			bc <= 16'h0000;
			ky <= '0;
		end else begin
			wr_p <= hsel && hready && htrans[1] && hwrite;
			wa <= haddr;
			if (wr_p && wa == ADDR_BLEND) bc <= hwdata[15:0] & BLEND_MASK;
			if (wr_p && wa == ADDR_KEY_RED) ky[2] <= hwdata[7:0];
			if (wr_p && wa == ADDR_KEY_GREEN) ky[1] <= hwdata[7:0];
			if (wr_p && wa == ADDR_KEY_BLUE) ky[0] <= hwdata[7:0];
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	main_shown_a: assert property (pix_in_valid && (!pix_in.in_overlay || hit) |-> ##2
		pix_out.from_main && pix_out.color == $past(pix_in.main_pixel_color, 2))
		else $error("main pixel not shown");
	blend_off_a: assert property (pix_in_valid && pix_in.in_overlay && !hit
		&& !bc[BIT_BLEND_EN] |-> ##2 pix_out.color == $past(pix_in.overlay_pixel_color, 2))
		else $error("overlay altered with blending off");
	zero_alpha_a: assert property (z && !bc[BIT_SWAP] |-> ##2
		pix_out.color == $past(pix_in.main_pixel_color, 2)) else $error("zero alpha wrong");
	swap_full_a: assert property (z && bc[BIT_SWAP] |-> ##2
		pix_out.color == $past(pix_in.overlay_pixel_color, 2)) else $error("swap wrong");
	out_delay_a: assert property (1'b1 |-> ##2 pix_out_valid == $past(pix_in_valid, 2))
		else $error("pixel latency wrong");
	lut_use_a: assert property (pix_out_valid |-> pix_out.gamma_lut_use
		== (pix_out.from_main && !$past(main_gamma_bypass))) else $error("gamma use wrong");
	bypass_wr_a: assert property (wr_p && wa == ADDR_GAMMA |=>
		main_gamma_bypass == $past(hwdata[BIT_MAIN_BYPASS])) else $error("bypass not updated");
	key_read_a: assert property (hsel && hready && htrans[1] && !hwrite
		&& haddr == ADDR_KEY_GREEN |=> hrdata == {24'h00_0000, ky[1]}) else $error("key read");
	cover property (pix_in_valid && hit);
	cover property (z && bc[BIT_SWAP]);
	cover property (pix_out_valid && main_gamma_bypass);
endmodule // blend_check
`default_nettype wire

// ==== overlay_alpha_key_gamma_ctrl_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module overlay_alpha_key_gamma_ctrl_test
	import overlay_blend_pkg::*;
;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, d, s = 32'd19395;
	logic [1:0] htrans = 2'h0;
	logic pix_in_valid = 1'b0, pix_out_valid, main_gamma_bypass;
	pixel_in_t pix_in = '0, p;
	pixel_out_t pix_out;
	logic [15:0] bc, gm;
	rgb_t ky = '0;
	logic fm;
	int error_cnt = 0, check_count = 0;
	always #20 hclk = ~hclk;
	overlay_alpha_key_gamma_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pix_in_valid(pix_in_valid),
		.pix_in(pix_in), .pix_out_valid(pix_out_valid), .pix_out(pix_out),
		.main_gamma_bypass(main_gamma_bypass));
	// ----------------------------------------
	// Bus, compare and model helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] v);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= v;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		d = hrdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_pix(input pixel_in_t q);
		check_count++;
		if ({pix_out_valid, pix_out} !== {1'b1, expc(q), fm, fm && !gm[14]}) begin
			error_cnt++;
			$display("[ERR] %0t pixel got %h", $time, pix_out);
		end
	endtask
	// Mirrors the blend arithmetic with plain integers
	function automatic rgb_t expc(pixel_in_t q);
		logic [7:0] m;
		int a, t, u;
		rgb_t r;
		if (!q.in_overlay || fm) return q.main_pixel_color;
		if (!bc[8]) return q.overlay_pixel_color;
		m = q.alpha_width == 2'h0 ? {q.map_alpha[0], 7'h00} :
			q.alpha_width == 2'h1 ? {q.map_alpha[3:0], 4'h0} : q.map_alpha;
		if (bc[14] && m != 8'h00) m = {1'b1, m[7:1]};
		a = bc[10:9] == 2'h1 ? m : bc[10:9] == 2'h2 ? (m * bc[7:0]) >> 8 : bc[7:0];
		for (int i = 0; i < 3; i++) begin
			t = bc[13] ? q.main_pixel_color[i] : q.overlay_pixel_color[i];
			u = bc[13] ? q.overlay_pixel_color[i] : q.main_pixel_color[i];
			r[i] = 8'((t * a + u * (256 - a)) >> 8);
		end
		return r;
	endfunction
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#1_000_000;
		error_cnt++;
		wrap_up;
	end
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int a = 0; a < 6; a++) begin
			bus(1'b0, a == 5 ? 32'h0000_2000 : ADDR_BLEND + 32'(8 * a), '0);
			chk(d, 32'h0000_0000);
			chk(32'({hreadyout, hresp}), 32'h0000_0002);
		end
		$display("reset and unmapped test done");
		for (int i = 0; i < 80; i++) begin
			bc = 16'(rnd()) & BLEND_MASK;
			bc[10:9] = 2'(i);
			if (i % 8 == 7 || i % 8 == 4) bc[7:0] = 8'h00;
			bus(1'b1, ADDR_BLEND, {16'(rnd()), bc});
			bc = 16'(hwdata) & BLEND_MASK;
			bus(1'b0, ADDR_BLEND, '0);
			chk(d, {16'h0000, bc});
			for (int c = 0; c < 3; c++) begin
				bus(1'b1, ADDR_KEY_RED + 32'(8 * c), i % 2 == 0 ? rnd() & 32'hFFFF_FFF8 : rnd());
				ky[2 - c] = hwdata[7:0];
				bus(1'b0, ADDR_KEY_RED + 32'(8 * c), '0);
				chk(d, {24'h00_0000, ky[2 - c]});
			end
			gm = 16'(rnd()) & GAMMA_MASK;
			bus(1'b1, ADDR_GAMMA, 32'(gm));
			@(posedge hclk);
			chk(32'(main_gamma_bypass), 32'(gm[14]));
			for (int j = 0; j < 6; j++) begin
				p = 59'({rnd(), rnd()});
				p.alpha_width = 2'(rnd() % 3);
				p.in_overlay = j != 0;
				if (j == 1) p.overlay_pixel_color = ky;
				fm = !p.in_overlay || (bc[12] && p.overlay_pixel_color == ky);
				pix_in <= p;
				pix_in_valid <= 1'b1;
				@(posedge hclk);
				pix_in_valid <= 1'b0;
				@(posedge hclk);
				@(posedge hclk);
				chk_pix(p);
			end
		end
		$display("blend and key test done");
		wrap_up;
	end
endmodule // overlay_alpha_key_gamma_ctrl_test
bind overlay_alpha_key_gamma_ctrl blend_check chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.pix_in_valid(pix_in_valid), .pix_in(pix_in), .pix_out_valid(pix_out_valid),
	.pix_out(pix_out), .main_gamma_bypass(main_gamma_bypass));
`default_nettype wire
